// ==== logic/dual_timer_pkg.sv ====
// Constants for the cascadable pair of 16-bit timers.
// Assumes an APB master at 20 MHz and word-indexed register offsets.
package dual_timer_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_LOW_COUNT = 10'h106;
	localparam logic [9:0] IDX_HOLD = 10'h108;
	localparam logic [9:0] IDX_HIGH_COUNT = 10'h10A;
	localparam logic [9:0] IDX_LOW_PERIOD = 10'h10C;
	localparam logic [9:0] IDX_HIGH_PERIOD = 10'h10E;
	localparam logic [9:0] IDX_LOW_CTRL = 10'h110;
	localparam logic [9:0] IDX_HIGH_CTRL = 10'h112;
	localparam logic [9:0] IDX_INT_STATUS = 10'h120;
	localparam logic [9:0] IDX_INT_MASK = 10'h122;
	// Control field positions
	localparam int CTL_TIMER_ON = 15;
	localparam int CTL_IDLE_STOP = 13;
	localparam int CTL_GATED = 6;
	localparam int CTL_PRESCALE_LO = 4;
	localparam int CTL_CASCADE = 3;
	localparam int CTL_CLOCK_SOURCE = 1;
	// Interrupt status bits
	localparam int INT_LOW = 0;
	localparam int INT_HIGH = 1;
	// Reset values
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	// Prescaler terminal counts for 1, 8, 64, 256
	localparam logic [7:0] PS_TERM_1 = 8'h00;
	localparam logic [7:0] PS_TERM_8 = 8'h07;
	localparam logic [7:0] PS_TERM_64 = 8'h3F;
	localparam logic [7:0] PS_TERM_256 = 8'hFF;
	typedef enum logic [1:0] {PS_DIV1 = 2'b00, PS_DIV8 = 2'b01, PS_DIV64 = 2'b10, PS_DIV256 = 2'b11} prescale_t;
endpackage

// ==== logic/dual_timer.sv ====
// Cascadable pair of 16-bit timers with an APB register file.
// Assumes count pins and idle indication are synchronous-safe inputs sampled on pclk.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module dual_timer
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and CPU state
	input wire logic external_count_pin_low,
	input wire logic external_count_pin_high,
	input wire logic cpu_idle,
	// Time base and events
	output logic [15:0] low_count_out,
	output logic [15:0] high_count_out,
	output logic [1:0] period_match_pulse,
	output logic adc_trigger,
	output logic irq
);
	import dual_timer_pkg::*;

	logic [15:0] cnt_reg [2];
	logic [15:0] per_reg [2];
	logic [15:0] ctl_reg [2];
	logic [15:0] hold_reg;
	logic [1:0] status_reg;
	logic [1:0] mask_reg;
	logic [31:0] prdata_reg;
	logic [1:0] match_reg;
	logic adc_reg;
	logic [1:0] sync1_reg, sync2_reg, prev_reg;
	logic [1:0] tick, timer_on, gated, gate_fall, wr_cnt, evt, set_evt;
	logic [7:0] ps_reg [2];
	logic [15:0] cfg [2];
	logic cascade, match32, wr_access, rd_access, setup, mapped;
	logic [9:0] idx;

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && penable && !pwrite;
	assign cascade = ctl_reg[0][CTL_CASCADE];
	assign match32 = {cnt_reg[1], cnt_reg[0]} == {per_reg[1], per_reg[0]};
	assign wr_cnt[0] = wr_access && idx == IDX_LOW_COUNT;
	assign wr_cnt[1] = wr_access && idx == IDX_HIGH_COUNT;

	// Address decode
	always_comb
	begin
		case (idx)
			IDX_LOW_COUNT, IDX_HOLD, IDX_HIGH_COUNT, IDX_LOW_PERIOD, IDX_HIGH_PERIOD,
			IDX_LOW_CTRL, IDX_HIGH_CTRL, IDX_INT_STATUS, IDX_INT_MASK: mapped = paddr[1:0] == 2'b00;
			default: mapped = 1'b0;
		endcase
	end

	// Two-stage synchronisers, third stage for edges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 2'b00;
			sync2_reg <= 2'b00;
			prev_reg <= 2'b00;
		end
		else
		begin
			sync1_reg <= {external_count_pin_high, external_count_pin_low};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// Per-half prescaler, tick and counter
	genvar h;
	generate
		for (h = 0; h < 2; h++)
		begin : g_half
			logic [7:0] term;
			logic src, freeze;
			// cascaded high half takes low setup
			assign cfg[h] = cascade ? ctl_reg[0] : ctl_reg[h];
			assign timer_on[h] = cfg[h][CTL_TIMER_ON];
			assign gated[h] = !cfg[h][CTL_CLOCK_SOURCE] && cfg[h][CTL_GATED];
			assign gate_fall[h] = timer_on[h] && gated[h] && prev_reg[h] && !sync2_reg[h];
			assign freeze = cpu_idle && cfg[h][CTL_IDLE_STOP];
			// synchronous counter edge or internal cycle
			assign src = cfg[h][CTL_CLOCK_SOURCE] ? (sync2_reg[h] && !prev_reg[h])
				: (!gated[h] || sync2_reg[h]);
			always_comb
			begin
				case (prescale_t'(cfg[h][CTL_PRESCALE_LO +: 2]))
					PS_DIV1: term = PS_TERM_1;
					PS_DIV8: term = PS_TERM_8;
					PS_DIV64: term = PS_TERM_64;
					PS_DIV256: term = PS_TERM_256;
					default: term = PS_TERM_1;
				endcase
			end
			// prescaler output taken on pclk in both halves
			assign tick[h] = timer_on[h] && src && !freeze && ps_reg[h] == term;
			// Prescaler cleared on count write or timer off
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					ps_reg[h] <= 8'h00;
				else if (wr_cnt[h] || !timer_on[h] || (timer_on[h] && src && !freeze && ps_reg[h] == term))
					ps_reg[h] <= 8'h00;
				else if (src && !freeze)
					ps_reg[h] <= ps_reg[h] + 8'h01;
			end
		end
	endgenerate

	// Low half counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg[0] <= COUNT_RESET;
		else if (wr_cnt[0])
			cnt_reg[0] <= pwdata[15:0];
		else if (cascade && tick[0])
			cnt_reg[0] <= match32 ? COUNT_RESET : cnt_reg[0] + 16'h0001;
		else if (!cascade && tick[0])
			cnt_reg[0] <= (cnt_reg[0] == per_reg[0]) ? COUNT_RESET : cnt_reg[0] + 16'h0001;
	end

	// High half counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg[1] <= COUNT_RESET;
		else if (wr_cnt[0] && cascade)
			cnt_reg[1] <= hold_reg;
		else if (wr_cnt[1])
			cnt_reg[1] <= pwdata[15:0];
		// high half takes carry of low half
		else if (cascade && tick[0])
			cnt_reg[1] <= match32 ? COUNT_RESET : cnt_reg[1] + {15'h0000, cnt_reg[0] == 16'hFFFF};
		else if (!cascade && tick[1])
			cnt_reg[1] <= (cnt_reg[1] == per_reg[1]) ? COUNT_RESET : cnt_reg[1] + 16'h0001;
	end

	// Period match events per half
	assign evt[0] = cascade ? (tick[0] && match32) : (tick[0] && cnt_reg[0] == per_reg[0]);
	assign evt[1] = cascade ? (tick[0] && match32) : (tick[1] && cnt_reg[1] == per_reg[1]);
	// cascaded events only on the high flag
	// match or gate fall sets high flag
	assign set_evt[INT_LOW] = !cascade && (evt[0] || gate_fall[0]);
	assign set_evt[INT_HIGH] = cascade ? (evt[1] || gate_fall[0]) : (evt[1] || gate_fall[1]);

	// Holding register, captured in the same setup cycle as the low word read data
	// capture on low count read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold_reg <= COUNT_RESET;
		else if (setup && !pwrite && idx == IDX_LOW_COUNT)
			hold_reg <= cnt_reg[1];
		else if (wr_access && idx == IDX_HOLD)
			hold_reg <= pwdata[15:0];
	end

	// Period and control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			per_reg[0] <= PERIOD_RESET;
			per_reg[1] <= PERIOD_RESET;
			ctl_reg[0] <= CTRL_RESET;
			ctl_reg[1] <= CTRL_RESET;
			mask_reg <= 2'b00;
		end
		else if (wr_access)
		begin
			case (idx)
				IDX_LOW_PERIOD: per_reg[0] <= pwdata[15:0];
				IDX_HIGH_PERIOD: per_reg[1] <= pwdata[15:0];
				IDX_LOW_CTRL: ctl_reg[0] <= pwdata[15:0];
				IDX_HIGH_CTRL: ctl_reg[1] <= pwdata[15:0];
				IDX_INT_MASK: mask_reg <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_reg <= 2'b00;
		else if (wr_access && idx == IDX_INT_STATUS)
			status_reg <= (status_reg & ~pwdata[1:0]) | set_evt;
		else
			status_reg <= status_reg | set_evt;
	end

	// Event pulses; ADC trigger on high half match
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			match_reg <= 2'b00;
			adc_reg <= 1'b0;
		end
		else
		begin
			match_reg <= evt;
			adc_reg <= evt[1];
		end
	end

	// Read data captured in setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h00000000;
		else if (setup && !pwrite)
		begin
			case (idx)
				IDX_LOW_COUNT: prdata_reg <= {16'h0000, cnt_reg[0]};
				IDX_HOLD: prdata_reg <= {16'h0000, hold_reg};
				IDX_HIGH_COUNT: prdata_reg <= {16'h0000, cnt_reg[1]};
				IDX_LOW_PERIOD: prdata_reg <= {16'h0000, per_reg[0]};
				IDX_HIGH_PERIOD: prdata_reg <= {16'h0000, per_reg[1]};
				IDX_LOW_CTRL: prdata_reg <= {16'h0000, ctl_reg[0]};
				IDX_HIGH_CTRL: prdata_reg <= {16'h0000, ctl_reg[1]};
				IDX_INT_STATUS: prdata_reg <= {30'h00000000, status_reg};
				IDX_INT_MASK: prdata_reg <= {30'h00000000, mask_reg};
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end

	// Outputs
	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	// time base for capture and compare
	assign low_count_out = cnt_reg[0];
	assign high_count_out = cnt_reg[1];
	assign period_match_pulse = match_reg;
	assign adc_trigger = adc_reg;
	assign irq = |(status_reg & mask_reg);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_cas_wrap;
		cascade && tick[0] && match32 && !wr_cnt[0] && !wr_cnt[1];
	endsequence
	sequence s_cleared32;
		cnt_reg[0] == 16'h0000 && cnt_reg[1] == 16'h0000 && status_reg[INT_HIGH];
	endsequence
	property p_cas_wrap;
		s_cas_wrap |=> s_cleared32;
	endproperty
	a_cas_wrap: assert property (p_cas_wrap) else $error("32-bit wrap failed");
	property p_split_wrap;
		!cascade && tick[0] && cnt_reg[0] == per_reg[0] && !wr_cnt[0] |=> cnt_reg[0] == 16'h0000 && status_reg[INT_LOW];
	endproperty
	a_split_wrap: assert property (p_split_wrap) else $error("16-bit wrap failed");
	property p_hold;
		setup && !pwrite && idx == IDX_LOW_COUNT |=> hold_reg == $past(cnt_reg[1]);
	endproperty
	a_hold: assert property (p_hold) else $error("holding not captured");
	property p_cwrite;
		wr_cnt[0] && cascade |=> cnt_reg[1] == $past(hold_reg) && cnt_reg[0] == $past(pwdata[15:0]);
	endproperty
	a_cwrite: assert property (p_cwrite) else $error("coherent write failed");
	property p_gate_hold;
		gated[0] && !sync2_reg[0] && !wr_cnt[0] |=> $stable(cnt_reg[0]);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("counted with gate low");
	property p_gate_flag;
		cascade && gate_fall[0] |=> status_reg[INT_HIGH] ##1 status_reg[INT_HIGH] || $past(wr_access);
	endproperty
	a_gate_flag: assert property (p_gate_flag) else $error("gate fall flag missing");
	property p_idle;
		cpu_idle && cfg[0][CTL_IDLE_STOP] && !wr_cnt[0] |=> $stable(cnt_reg[0]);
	endproperty
	a_idle: assert property (p_idle) else $error("counted in idle");
	property p_adc;
		adc_trigger |-> $past(evt[1]) && period_match_pulse[1];
	endproperty
	a_adc: assert property (p_adc) else $error("stray ADC trigger");
	property p_cas_flag;
		cascade && !status_reg[INT_LOW] |=> !status_reg[INT_LOW];
	endproperty
	a_cas_flag: assert property (p_cas_flag) else $error("low flag set in cascade");
endmodule

// ==== verification/count_pin_model.sv ====
// Source for one external count or gate pin.
// Assumes the bench calls its tasks right after a pclk edge.
`timescale 1ns/10ps
module count_pin_model
(
	// Clock and pin
	input wire logic pclk,
	output logic pin
);
	// Pin rests low between bursts
	initial pin = 1'b0;
	// rising edges wide enough to sync
	task automatic pulses(input int n);
		repeat (n)
		begin
			pin <= 1'b1;
			repeat (4) @(posedge pclk);
			pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic gate(input int n);
		pin <= 1'b1;
		repeat (n) @(posedge pclk);
		pin <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// ==== verification/cascadable_dual_16bit_timer_tb_top.sv ====
// Self-checking bench for the cascadable timer pair.
// Assumes a 20 MHz pclk and zero-wait APB answers.
`timescale 1ns/10ps
module cascadable_dual_16bit_timer_tb_top;
	import dual_timer_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic cpu_idle = 1'b0;
	logic [31:0] prdata, rd, r1, r2, r3;
	logic [31:0] lfsr = 32'h5A5A50DC;
	logic pready, pslverr, err, pin_lo, pin_hi, adc_trigger, irq;
	logic [15:0] low_count_out, high_count_out;
	logic [1:0] period_match_pulse;
	int n_fail = 0;
	int cmp_count = 0;
	int n_adc, n_lo, n_hi;
	// Clock
	always #25 pclk = ~pclk;
	dual_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_count_pin_low(pin_lo), .external_count_pin_high(pin_hi),
		.cpu_idle(cpu_idle), .low_count_out(low_count_out), .high_count_out(high_count_out),
		.period_match_pulse(period_match_pulse), .adc_trigger(adc_trigger), .irq(irq));
	count_pin_model PIN_LO (.pclk(pclk), .pin(pin_lo));
	count_pin_model PIN_HI (.pclk(pclk), .pin(pin_hi));
	// Event pulse counters
	always @(posedge pclk)
	begin
		n_adc += int'(adc_trigger === 1'b1);
		n_lo += int'(period_match_pulse[0] === 1'b1);
		n_hi += int'(period_match_pulse[1] === 1'b1);
	end
	function automatic logic [31:0] rnd16();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return {16'h0000, lfsr[15:0]};
	endfunction
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic near(input string s, input int e, input logic [31:0] g);
		cmp_count++;
		if ((g >= e - 1 && g <= e + 1) !== 1'b1)
		begin
			n_fail++;
			$display("unexpected %s expected %0d seen %0d", s, e, g);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
	endtask
	task automatic rdc(input logic [9:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h00000000);
		check($sformatf("reg %h", i), e, rd);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		report_and_stop();
	end
	// Main sequence
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(IDX_LOW_PERIOD, 32'h0000FFFF);
		rdc(IDX_LOW_CTRL, 32'h00000000);
		apb(1'b0, 10'h001, 32'h00000000);
		check("slverr", 32'h00000001, {31'h0, err});
		check("rdata", 32'h00000000, rd);
		// Coherent access with cascade set and timer stopped
		r1 = rnd16();
		r2 = rnd16();
		r3 = rnd16();
		wr(IDX_LOW_CTRL, 32'h00000008);
		wr(IDX_HIGH_CTRL, 32'h00008000);
		wr(IDX_HOLD, r1);
		wr(IDX_LOW_COUNT, r2);
		repeat (10) @(posedge pclk);
		rdc(IDX_HIGH_COUNT, r1);
		wr(IDX_HIGH_COUNT, r3);
		rdc(IDX_LOW_COUNT, r2);
		rdc(IDX_HOLD, r3);
		check("low_count_out", r2, {16'h0000, low_count_out});
		check("high_count_out", r3, {16'h0000, high_count_out});
		// Carry from low word into high word
		wr(IDX_HIGH_CTRL, 32'h00000000);
		wr(IDX_HOLD, 32'h00000000);
		wr(IDX_LOW_COUNT, 32'h0000FFFD);
		wr(IDX_LOW_CTRL, 32'h00008008);
		repeat (4) @(posedge pclk);
		wr(IDX_LOW_CTRL, 32'h00000008);
		rdc(IDX_HIGH_COUNT, 32'h00000001);
		apb(1'b0, IDX_LOW_COUNT, 32'h00000000);
		near("low word", 4, rd);
		rdc(IDX_HOLD, 32'h00000001);
		// Combined period match every six cycles
		wr(IDX_HOLD, 32'h00000000);
		wr(IDX_LOW_COUNT, 32'h00000000);
		wr(IDX_LOW_PERIOD, 32'h00000005);
		wr(IDX_HIGH_PERIOD, 32'h00000000);
		n_adc = 0;
		wr(IDX_LOW_CTRL, 32'h00008008);
		repeat (57) @(posedge pclk);
		wr(IDX_LOW_CTRL, 32'h00000008);
		near("adc", 10, n_adc);
		rdc(IDX_INT_STATUS, 32'h00000002);
		check("irq", 32'h00000000, {31'h0, irq});
		wr(IDX_INT_MASK, 32'h00000002);
		check("irq", 32'h00000001, {31'h0, irq});
		wr(IDX_INT_STATUS, 32'h00000002);
		check("irq", 32'h00000000, {31'h0, irq});
		// Split halves with their own periods
		wr(IDX_LOW_CTRL, 32'h00000000);
		wr(IDX_LOW_COUNT, 32'h00000000);
		wr(IDX_HIGH_COUNT, 32'h00000000);
		wr(IDX_LOW_PERIOD, 32'h00000003);
		wr(IDX_HIGH_PERIOD, 32'h00000007);
		n_lo = 0;
		n_hi = 0;
		wr(IDX_LOW_CTRL, 32'h00008000);
		wr(IDX_HIGH_CTRL, 32'h00008000);
		repeat (74) @(posedge pclk);
		wr(IDX_LOW_CTRL, 32'h00000000);
		wr(IDX_HIGH_CTRL, 32'h00000000);
		near("low match", 20, n_lo);
		near("high match", 10, n_hi);
		rdc(IDX_INT_STATUS, 32'h00000003);
		wr(IDX_INT_MASK, 32'h00000001);
		check("irq", 32'h00000001, {31'h0, irq});
		wr(IDX_INT_STATUS, 32'h00000001);
		check("irq", 32'h00000000, {31'h0, irq});
		// Every prescale code over a fixed window
		wr(IDX_LOW_PERIOD, 32'h0000FFFF);
		for (int ps = 0; ps < 4; ps++)
		begin
			wr(IDX_LOW_COUNT, 32'h00000000);
			wr(IDX_LOW_CTRL, 32'h00008000 | (ps << 4));
			repeat (509) @(posedge pclk);
			wr(IDX_LOW_CTRL, 32'h00000000);
			apb(1'b0, IDX_LOW_COUNT, 32'h00000000);
			near("prescaled", 512 >> (ps == 3 ? 8 : 3 * ps), rd);
		end
		wr(IDX_LOW_COUNT, 32'h00000000);
		wr(IDX_LOW_CTRL, 32'h0000A002);
		cpu_idle <= 1'b1;
		PIN_LO.pulses(3);
		rdc(IDX_LOW_COUNT, 32'h00000000);
		cpu_idle <= 1'b0;
		PIN_LO.pulses(5);
		rdc(IDX_LOW_COUNT, 32'h00000005);
		wr(IDX_LOW_CTRL, 32'h00008002);
		cpu_idle <= 1'b1;
		PIN_LO.pulses(2);
		rdc(IDX_LOW_COUNT, 32'h00000007);
		cpu_idle <= 1'b0;
		wr(IDX_HIGH_COUNT, 32'h00000000);
		wr(IDX_HIGH_CTRL, 32'h00008002);
		PIN_HI.pulses(4);
		rdc(IDX_HIGH_COUNT, 32'h00000004);
		// Gated accumulation in cascade
		wr(IDX_HIGH_CTRL, 32'h00000000);
		wr(IDX_INT_STATUS, 32'h00000003);
		wr(IDX_HOLD, 32'h00000000);
		wr(IDX_LOW_COUNT, 32'h00000000);
		wr(IDX_HIGH_PERIOD, 32'h0000FFFF);
		wr(IDX_LOW_CTRL, 32'h00008048);
		PIN_LO.gate(20);
		apb(1'b0, IDX_LOW_COUNT, 32'h00000000);
		near("gated", 20, rd);
		rdc(IDX_INT_STATUS, 32'h00000002);
		report_and_stop();
	end
endmodule
